/* sf_pkg.sv */
// package for the range and address special-function decoder
// assumes: 10 MHz ref_clk, command fields arrive already parsed
package sf_pkg;
    // command function numbers
    localparam logic [4:0] FUNC_RANGE = 5'h01;
    localparam logic [4:0] FUNC_DC_RANGE = 5'h02;
    localparam logic [4:0] FUNC_ADDR = 5'h15;
    // suffix limits
    localparam logic [4:0] RANGE_MAX_SUFFIX = 5'h13;
    localparam logic [4:0] DC_RANGE_MAX_SUFFIX = 5'h04;
    // power-up address and flags
    localparam logic [4:0] ADDR_RESET = 5'h1C;
    localparam logic ADDR_FLAG_RESET = 1'b0;
    localparam logic SRQ_RESET = 1'b0;
    // error code shown on overload under manual range
    localparam logic [7:0] ERR_OVERLOAD = 8'h1E;
    // flash time of an entered code on the left display
    localparam int FLASH_TIME_MS = 500;
    localparam int CLK_HZ = 10_000_000;
    localparam int FLASH_CYCLES = FLASH_TIME_MS * (CLK_HZ / 1000);
    // register map of the plain port
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ADDR_SW = 4'h1;
    localparam logic [3:0] REG_RANGE = 4'h2;
    localparam logic [3:0] REG_DISPLAY = 4'h3;
    // command register fields
    localparam int CMD_FUNC_LSB = 8;
    localparam int CMD_SUFFIX_LSB = 0;
    // left display modes
    typedef enum logic [2:0] {
        DISP_NORMAL = 3'b000,
        DISP_CODE = 3'b001,
        DISP_BLANK = 3'b010,
        DISP_ADDR_BIN = 3'b011,
        DISP_ADDR_DEC = 3'b100,
        DISP_ERROR = 3'b101
    } disp_mode_t;
endpackage : sf_pkg

/* pin_sync.sv */
// three-stage synchroniser for a group of pins
// assumes: pins are asynchronous to clk; output changes when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    // pins in, clean value out
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // per-bit filter: update only on stage agreement
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    s1_q[i] <= 1'b0;
                    s2_q[i] <= 1'b0;
                    s3_q[i] <= 1'b0;
                    pinOut[i] <= 1'b0;
                end else if (clkEn) begin
                    s1_q[i] <= pinIn[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    if (s2_q[i] == s3_q[i]) begin
                        pinOut[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate
endmodule : pin_sync

/* flash_timer.sv */
// one-shot timer for showing an entered code on the left display
// assumes: start is a one-cycle pulse from the same clock
`timescale 1ns/1ps
module flash_timer #(
    parameter int CYCLES = 5_000_000
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    // control
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [31:0] cnt_q;

    // count down from start, pulse done at the end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 32'h0000_0000;
            done <= 1'b0;
        end else if (clkEn) begin
            done <= 1'b0;
            if (start) begin
                cnt_q <= 32'(CYCLES);
            end else if (cnt_q != 32'h0000_0000) begin
                cnt_q <= cnt_q - 32'h0000_0001;
                if (cnt_q == 32'h0000_0001) begin
                    done <= 1'b1;
                end
            end
        end
    end

    assign busy = (cnt_q != 32'h0000_0000);
endmodule : flash_timer

/* range_addr_sf.sv */
// special-function decoder: address display and input range selection
// assumes: commands come pre-parsed over the plain register port; address switches are raw pins
//
// How it works
// RL1: address display follows the switches live, no need to re-enter command
// RL2: address switches default 28, talk-only and listen-only clear
// RL3: service-request flag clears at reset
// RL4: special functions only taken from the remote command register
// RL5: code 21.0 shows five address bits as binary on left display
// RL6: binary display puts talk-only, listen-only, service-request on right display
// RL7: either address command turns off key lights and annunciators
// RL8: talk-only and listen-only together act as talk-only
// RL9: all address bits and talk-only set gives status-only talk mode
// RL10: all ones with service-request clear flags interface board absent
// RL11: code 21.1 shows address prefix left and decimal address right
// RL12: local key then a function key clears address display, new mode
// RL13: dc codes 2.0 auto, 2.1 to 2.4 select 300V,64V,16V,4V
// RL14: non-dc codes 1.0 auto, 1.1 to 1.19 select descending ranges
// RL15: dc auto range uses both dc and ac level
// RL16: auto mode sets attenuator and amplifier gain from signal level
// RL17: dc code flashes, blanks, then frequency except in dc mode
// RL18: non-dc code shown, then display returns to frequency
// RL19: reset or automatic operation puts both range functions in auto
// RL20: overload under manual range shows error 30
// RL21: no error for manual gain unless overload happens
// RL22: suffix zero returns only that function to automatic
// RL23: command is function, point, suffix, terminator; unknown suffix ignored
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module range_addr_sf
    import sf_pkg::*;
#(
    parameter int FLASH_CNT = FLASH_CYCLES
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    // front-panel and pins
    input wire logic [6:0] addrSwitch,
    input wire logic localReturnKey,
    input wire logic functionKey,
    input wire logic autoOpKey,
    input wire logic serviceRequest,
    input wire logic overload,
    input wire logic boardPresent,
    // auto-ranging level hints from the detectors
    input wire logic [4:0] acAutoRange,
    input wire logic [2:0] dcAutoRange,
    input wire logic [2:0] dcLevelRange,
    input wire logic dcMode,
    // outputs
    output logic [4:0] rangeSel,
    output logic [2:0] dcRangeSel,
    output logic rangeAuto,
    output logic dcRangeAuto,
    output logic [2:0] leftMode,
    output logic [7:0] leftValue,
    output logic [7:0] rightValue,
    output logic keyLightsOn,
    output logic talkOnly,
    output logic listenOnly,
    output logic statusOnly,
    output logic boardAbsent
);
    ////////////////////////////////////////////////////////////////////////////
    // synchronised pins
    logic [6:0] swSync;
    logic [2:0] keySync;
    logic [1:0] detSync;
    logic flashDone;
    logic flashStart;

    pin_sync #(.WIDTH(7)) u_sw_sync (
        .clk(ref_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .pinIn(addrSwitch),
        .pinOut(swSync)
    );

    pin_sync #(.WIDTH(3)) u_key_sync (
        .clk(ref_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .pinIn({autoOpKey, functionKey, localReturnKey}),
        .pinOut(keySync)
    );

    pin_sync #(.WIDTH(2)) u_det_sync (
        .clk(ref_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .pinIn({overload, serviceRequest}),
        .pinOut(detSync)
    );

    flash_timer #(.CYCLES(FLASH_CNT)) u_flash (
        .clk(ref_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .start(flashStart),
        .busy(),
        .done(flashDone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // command decode
    logic [4:0] cmdFunc;
    logic [4:0] cmdSuffix;
    logic cmdWr;
    logic addrCmd;
    logic rangeCmd;
    logic dcRangeCmd;
    logic [2:0] keyPrev_q;
    logic autoOpEdge;
    logic functionEdge;
    logic localEdge;
    logic localArmed_q;
    logic srq_q;
    logic srqShown;
    logic [4:0] switchAddr;
    logic switchTalk;
    logic switchListen;

    assign cmdFunc = regWdata[CMD_FUNC_LSB +: 5];
    assign cmdSuffix = regWdata[CMD_SUFFIX_LSB +: 5];
    assign cmdWr = regWr && (regAddr == REG_CMD); // RL4
    // unknown suffix matches nothing and is dropped
    assign addrCmd = cmdWr && (cmdFunc == FUNC_ADDR) && (cmdSuffix <= 5'h01); // RL23
    assign rangeCmd = cmdWr && (cmdFunc == FUNC_RANGE) && (cmdSuffix <= RANGE_MAX_SUFFIX); // RL23
    assign dcRangeCmd = cmdWr && (cmdFunc == FUNC_DC_RANGE) && (cmdSuffix <= DC_RANGE_MAX_SUFFIX); // RL23
    // a range code restarts the flash time
    assign flashStart = (rangeCmd || dcRangeCmd) && clkEn;
    // rising edges of the synchronised keys
    assign autoOpEdge = keySync[2] && !keyPrev_q[2];
    assign functionEdge = keySync[1] && !keyPrev_q[1];
    assign localEdge = keySync[0] && !keyPrev_q[0];

    // switches: five address bits, talk-only, listen-only; factory 28 via inversion
    assign switchAddr = swSync[4:0] ^ ADDR_RESET; // RL2
    assign switchTalk = swSync[5] ^ ADDR_FLAG_RESET; // RL2
    assign switchListen = swSync[6] ^ ADDR_FLAG_RESET; // RL2

    // key edge memory
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            keyPrev_q <= 3'b000;
        end else if (clkEn) begin
            keyPrev_q <= keySync;
        end
    end

    // service-request flag follows the bus status
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            srq_q <= SRQ_RESET; // RL3
        end else if (clkEn) begin
            srq_q <= detSync[0];
        end
    end

    // service-request bit reads zero without the interface board
    assign srqShown = boardPresent ? srq_q : 1'b0; // RL10

    ////////////////////////////////////////////////////////////////////////////
    // range selection
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rangeAuto <= 1'b1; // RL19
            rangeSel <= 5'h00;
        end else if (clkEn) begin
            if (autoOpEdge) begin
                rangeAuto <= 1'b1; // RL19
            end else if (rangeCmd) begin
                rangeAuto <= (cmdSuffix == 5'h00); // RL22
                if (cmdSuffix != 5'h00) begin
                    rangeSel <= cmdSuffix; // RL14
                end
            end
            // auto range tracks the detector pick
            if (rangeAuto && !rangeCmd) begin
                rangeSel <= acAutoRange; // RL16
            end
        end
    end

    // dc range: 1..4 = 300V/40dB, 64V/24dB, 16V/12dB, 4V/0dB
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dcRangeAuto <= 1'b1; // RL19
            dcRangeSel <= 3'b000;
        end else if (clkEn) begin
            if (autoOpEdge) begin
                dcRangeAuto <= 1'b1; // RL19
            end else if (dcRangeCmd) begin
                dcRangeAuto <= (cmdSuffix == 5'h00); // RL22
                if (cmdSuffix != 5'h00) begin
                    dcRangeSel <= cmdSuffix[2:0]; // RL13
                end
            end
            if (dcRangeAuto && !dcRangeCmd) begin
                // the more sensitive-limiting of dc and ac demand wins
                dcRangeSel <= (dcLevelRange < dcAutoRange) ? dcLevelRange : dcAutoRange; // RL15
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // display control
    disp_mode_t mode_q;
    logic [7:0] codeShown_q;
    logic overErr;

    assign overErr = detSync[1] && ((!rangeAuto && !dcMode) || (!dcRangeAuto && dcMode)); // RL20 RL21

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= DISP_NORMAL;
            codeShown_q <= 8'h00;
            localArmed_q <= 1'b0;
            keyLightsOn <= 1'b1;
        end else if (clkEn) begin
            if (addrCmd) begin
                mode_q <= (cmdSuffix == 5'h00) ? DISP_ADDR_BIN : DISP_ADDR_DEC; // RL5 RL11
                keyLightsOn <= 1'b0; // RL7
                localArmed_q <= 1'b0;
            end else if (rangeCmd || dcRangeCmd) begin
                mode_q <= DISP_CODE; // RL17 RL18
                codeShown_q <= {cmdFunc[2:0], cmdSuffix};
            end else if (flashDone) begin
                // dc code blanks and stays blank in dc mode
                mode_q <= (dcMode && codeShown_q[7:5] == FUNC_DC_RANGE[2:0]) ? DISP_BLANK : DISP_NORMAL; // RL17 RL18
            end else if (localEdge) begin
                localArmed_q <= 1'b1;
            end else if (functionEdge && localArmed_q) begin
                mode_q <= DISP_NORMAL; // RL12
                keyLightsOn <= 1'b1;
                localArmed_q <= 1'b0;
            end else if (overErr && mode_q == DISP_NORMAL) begin
                mode_q <= DISP_ERROR; // RL20
            end else if (!overErr && mode_q == DISP_ERROR) begin
                mode_q <= DISP_NORMAL; // RL21
            end
        end
    end

    // display content, refreshed every cycle from live switches
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            leftMode <= 3'b000;
            leftValue <= 8'h00;
            rightValue <= 8'h00;
        end else if (clkEn) begin
            leftMode <= mode_q;
            unique case (mode_q)
                DISP_ADDR_BIN: begin
                    leftValue <= {3'b000, switchAddr}; // RL1 RL5
                    rightValue <= {5'b00000, switchTalk, switchListen, srqShown}; // RL6
                end
                DISP_ADDR_DEC: begin
                    leftValue <= 8'h00;
                    rightValue <= {3'b000, switchAddr}; // RL1 RL11
                end
                DISP_CODE: begin
                    leftValue <= codeShown_q;
                    rightValue <= 8'h00;
                end
                DISP_ERROR: begin
                    leftValue <= ERR_OVERLOAD; // RL20
                    rightValue <= 8'h00;
                end
                DISP_NORMAL, DISP_BLANK: begin
                    leftValue <= 8'h00;
                    rightValue <= 8'h00;
                end
                default: begin
                    leftValue <= 8'h00;
                    rightValue <= 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus role flags, talk wins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            talkOnly <= 1'b0;
            listenOnly <= 1'b0;
        end else if (clkEn) begin
            talkOnly <= switchTalk; // RL8
            listenOnly <= switchListen && !switchTalk; // RL8
        end
    end

    // status-only talker
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            statusOnly <= 1'b0;
        end else if (clkEn) begin
            statusOnly <= (&switchAddr) && switchTalk; // RL9
        end
    end

    // interface board missing
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            boardAbsent <= 1'b0;
        end else if (clkEn) begin
            boardAbsent <= !boardPresent; // RL10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read, data in the cycle after the strobe
    logic [15:0] addrWord;
    logic [15:0] rangeWord;
    logic [15:0] dispWord;

    // one read word per mapped register except REG_CMD, which reads zero
    assign addrWord = {8'h00, srqShown, switchListen, switchTalk, switchAddr};
    assign rangeWord = {3'b000, dcRangeAuto, dcRangeSel, rangeAuto, 3'b000, rangeSel};
    assign dispWord = {5'b00000, mode_q, codeShown_q};

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= 16'h0000;
        end else if (clkEn) begin
            regRdata <= 16'h0000;
            if (regRd) begin
                unique case (regAddr)
                    REG_ADDR_SW: regRdata <= addrWord; // RL10
                    REG_RANGE: regRdata <= rangeWord;
                    REG_DISPLAY: regRdata <= dispWord;
                    default: regRdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule : range_addr_sf

/* sf_ctl_model.sv */
// remote bus controller model: sends program codes, reads registers
// assumes: caller sits just after a rising edge; slave never stalls
`timescale 1ns/1ps
module sf_ctl_model
    import sf_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // register port
    output logic [3:0] regAddr,
    output logic [15:0] regWdata,
    output logic regWr,
    output logic regRd,
    input wire logic [15:0] regRdata
);
    ////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        regAddr = 4'h0;
        regWdata = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
    end

    // one program code: function, point, suffix, terminator as one write
    task automatic send(input logic [4:0] f, input logic [4:0] s);
        @(posedge ref_clk);
        regAddr <= REG_CMD;
        regWdata <= {3'b000, f, 3'b000, s};
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        // released lines show the inverse, not a stale copy
        regAddr <= ~REG_CMD;
        regWdata <= ~{3'b000, f, 3'b000, s};
    endtask : send

    // one read, data taken in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        regAddr <= ~a;
        @(negedge ref_clk);
        d = regRdata;
    endtask : rd
endmodule : sf_ctl_model

/* range_addr_sf_assertions.sv */
// port checker for the range and address decoder
// assumes: bound to range_addr_sf, one clock, clkEn gates all state
`timescale 1ns/1ps
module range_addr_sf_checker
    import sf_pkg::*;
#(
    parameter int FLASH_CNT = FLASH_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdata,
    // decoder outputs
    input wire logic [4:0] rangeSel,
    input wire logic [2:0] dcRangeSel,
    input wire logic rangeAuto,
    input wire logic dcRangeAuto,
    input wire logic [2:0] leftMode,
    input wire logic [7:0] leftValue,
    input wire logic keyLightsOn,
    input wire logic talkOnly,
    input wire logic listenOnly
);
    logic cmdWr;
    logic [4:0] fn;
    logic [4:0] suf;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////
    // decoded command write
    assign cmdWr = clkEn && regWr && regAddr == REG_CMD;
    assign fn = regWdata[12:8];
    assign suf = regWdata[4:0];

    a_dc_manual_sel: assert property (
        cmdWr && fn == FUNC_DC_RANGE && suf inside {[5'h01:5'h04]}
        |=> {2'b00, dcRangeSel} == $past(suf) && !dcRangeAuto) else $error("dc range not taken");
    a_dc_auto_back: assert property (
        cmdWr && fn == FUNC_DC_RANGE && suf == 5'h00 |=> dcRangeAuto) else $error("dc auto not set");
    a_rng_manual_sel: assert property (
        cmdWr && fn == FUNC_RANGE && suf inside {[5'h01:5'h13]}
        |=> rangeSel == $past(suf) && !rangeAuto) else $error("range not taken");
    a_rng_auto_back: assert property (
        cmdWr && fn == FUNC_RANGE && suf == 5'h00 |=> rangeAuto && dcRangeAuto == $past(dcRangeAuto))
        else $error("range auto not set alone");
    a_bad_suffix_kept: assert property (
        cmdWr && fn == FUNC_DC_RANGE && suf > 5'h04 && !dcRangeAuto
        |=> $stable(dcRangeSel) && !dcRangeAuto) else $error("bad suffix changed dc range");
    a_addr_lights_off: assert property (
        cmdWr && fn == FUNC_ADDR && suf <= 5'h01 |-> ##[1:2] !keyLightsOn) else $error("key lights stay on");
    a_rd_unmapped_zero: assert property (
        clkEn && regRd && regAddr > 4'h3 |=> regRdata == 16'h0000) else $error("unmapped read not zero");
    a_rd_idle_zero: assert property (
        clkEn && !regRd |=> regRdata == 16'h0000) else $error("read data outside slot");
    a_talk_over_listen: assert property (
        talkOnly |-> !listenOnly) else $error("talk and listen both on");
    a_err_code_value: assert property (
        leftMode == DISP_ERROR |-> leftValue == ERR_OVERLOAD) else $error("wrong error code");

    // main scenarios reached
    c_dc_sel: cover property (cmdWr && fn == FUNC_DC_RANGE && suf == 5'h04);
    c_err: cover property (leftMode == DISP_ERROR);
    c_addr_bin: cover property (leftMode == DISP_ADDR_BIN);
endmodule : range_addr_sf_checker

bind range_addr_sf range_addr_sf_checker #(.FLASH_CNT(FLASH_CNT)) u_chk (.ref_clk, .resetn, .clkEn, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .rangeSel, .dcRangeSel, .rangeAuto, .dcRangeAuto, .leftMode,
    .leftValue, .keyLightsOn, .talkOnly, .listenOnly);

/* range_and_address_special_functions_bench.sv */
// self-checking bench for the range and address decoder
// assumes: controller model drives the register port, bench drives pins
`timescale 1ns/1ps
module range_and_address_special_functions_bench;
    import sf_pkg::*;
    localparam int FL = 8;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] regAddr;
    logic [15:0] regWdata, regRdata, d;
    logic regWr, regRd;
    logic [6:0] addrSwitch = 7'h00;
    logic localReturnKey = 1'b0, functionKey = 1'b0, autoOpKey = 1'b0;
    logic serviceRequest = 1'b0, overload = 1'b0, boardPresent = 1'b1, dcMode = 1'b0, clkEn = 1'b1;
    logic [4:0] rangeSel;
    logic [2:0] dcRangeSel, leftMode;
    logic rangeAuto, dcRangeAuto, keyLightsOn, talkOnly, listenOnly, statusOnly, boardAbsent;
    logic [7:0] leftValue, rightValue;
    int nErrors = 0, numChecks = 0, cycles = 0;

    ////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nErrors++;
            final_report();
        end
    end

    sf_ctl_model u_ctl (.ref_clk(ref_clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata));
    range_addr_sf #(.FLASH_CNT(FL)) u_dut (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .addrSwitch(addrSwitch), .localReturnKey(localReturnKey), .functionKey(functionKey),
        .autoOpKey(autoOpKey), .serviceRequest(serviceRequest), .overload(overload),
        .boardPresent(boardPresent), .acAutoRange(5'h03), .dcAutoRange(3'h2), .dcLevelRange(3'h3),
        .dcMode(dcMode), .rangeSel(rangeSel), .dcRangeSel(dcRangeSel), .rangeAuto(rangeAuto),
        .dcRangeAuto(dcRangeAuto), .leftMode(leftMode), .leftValue(leftValue), .rightValue(rightValue),
        .keyLightsOn(keyLightsOn), .talkOnly(talkOnly), .listenOnly(listenOnly), .statusOnly(statusOnly),
        .boardAbsent(boardAbsent));

    // compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        numChecks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            nErrors++;
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    // key press long enough for the synchroniser: 0 local, 1 function, 2 auto
    task automatic press(input int k);
        @(posedge ref_clk);
        {autoOpKey, functionKey, localReturnKey} <= 3'b001 << k;
        repeat (6) @(posedge ref_clk);
        {autoOpKey, functionKey, localReturnKey} <= 3'b000;
        step(6);
    endtask : press

    task automatic t_reset;
        chk("rangeAuto", 1, rangeAuto);
        chk("dcRangeAuto", 1, dcRangeAuto);
        u_ctl.rd(REG_ADDR_SW, d);
        chk("addr word", 16'h001c, d);
        u_ctl.rd(4'hf, d);
        chk("unmapped", 16'h0000, d);
    endtask : t_reset

    task automatic t_dc;
        for (int s = 1; s <= 4; s++) begin
            u_ctl.send(FUNC_DC_RANGE, 5'(s));
            step(2);
            chk("dcRangeSel", 16'(s), dcRangeSel);
            chk("dcRangeAuto", 0, dcRangeAuto);
        end
        chk("flash mode", DISP_CODE, leftMode);
        chk("flash code", 16'h0044, leftValue);
        step(FL + 4);
        chk("after flash", DISP_NORMAL, leftMode);
        u_ctl.send(FUNC_DC_RANGE, 5'h05);
        step(2);
        chk("bad suffix", 4, dcRangeSel);
        dcMode <= 1'b1;
        u_ctl.send(FUNC_DC_RANGE, 5'h00);
        step(2);
        chk("dc auto", 1, dcRangeAuto);
        step(FL + 4);
        chk("dc blank", DISP_BLANK, leftMode);
        dcMode <= 1'b0;
    endtask : t_dc

    task automatic t_range;
        logic [4:0] tbl[3] = '{5'h01, 5'h0a, 5'h13};
        foreach (tbl[i]) begin
            u_ctl.send(FUNC_RANGE, tbl[i]);
            step(2);
            chk("rangeSel", 16'(tbl[i]), rangeSel);
            chk("rangeAuto", 0, rangeAuto);
        end
        u_ctl.send(FUNC_RANGE, 5'h14);
        step(2);
        chk("bad suffix", 19, rangeSel);
        clkEn <= 1'b0;
        u_ctl.send(FUNC_RANGE, 5'h05);
        step(2);
        chk("frozen", 19, rangeSel);
        clkEn <= 1'b1;
        overload <= 1'b1;
        step(8);
        chk("err mode", DISP_ERROR, leftMode);
        chk("err code", 16'h001e, leftValue);
        u_ctl.send(FUNC_RANGE, 5'h00);
        step(FL + 6);
        chk("rangeAuto", 1, rangeAuto);
        chk("no err auto", DISP_NORMAL, leftMode);
        overload <= 1'b0;
        u_ctl.send(FUNC_RANGE, 5'h07);
        u_ctl.send(FUNC_DC_RANGE, 5'h02);
        press(2);
        chk("auto op", 3, {rangeAuto, dcRangeAuto});
        u_ctl.rd(REG_RANGE, d);
        chk("range word", 16'h1503, d);
    endtask : t_range

    task automatic t_addr;
        serviceRequest <= 1'b1;
        u_ctl.send(FUNC_ADDR, 5'h00);
        step(8);
        chk("lights", 0, keyLightsOn);
        chk("bin mode", DISP_ADDR_BIN, leftMode);
        chk("bin addr", 16'h001c, leftValue);
        chk("flags", 16'h0001, rightValue);
        addrSwitch <= 7'h23;
        step(6);
        chk("live addr", 16'h001f, leftValue);
        chk("flags", 16'h0005, rightValue);
        chk("status", 1, statusOnly);
        addrSwitch <= 7'h63;
        serviceRequest <= 1'b0;
        boardPresent <= 1'b0;
        step(6);
        chk("talk", 2, {talkOnly, listenOnly});
        chk("absent", 1, boardAbsent);
        addrSwitch <= 7'h00;
        boardPresent <= 1'b1;
        u_ctl.send(FUNC_ADDR, 5'h01);
        step(8);
        chk("dec mode", DISP_ADDR_DEC, leftMode);
        chk("prefix", 0, leftValue);
        chk("dec addr", 16'h001c, rightValue);
        press(0);
        press(1);
        chk("cleared", DISP_NORMAL, leftMode);
        chk("lights back", 1, keyLightsOn);
    endtask : t_addr

    // verdict and end of run
    task automatic final_report;
        if (nErrors == 0 && numChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        step(6);
        t_reset();
        t_dc();
        t_range();
        t_addr();
        final_report();
    end
endmodule : range_and_address_special_functions_bench
